// [core/lscp_parser.sv]
// command interpreter for the laser controller serial link
`timescale 1ns/1ps
`default_nettype none
`include "lscp_consts.svh"
// Behaviour
// - trigger fires after 3 us plus steps
// - delay count limited to 0..3500
// - delay change refused in random mode
// - emitter hours step per six minutes on
// - head hours step per six powered minutes
// - supply hours step per six powered minutes
// - fault query returns code, zero if none
// - keep sixteen fault codes, blank separated
// - active list up to sixteen, else zero
// - buffer fifty energy readings, else zero
// - pulse total reported in thousands
// - port query returns active-level bit mask
// - only seven listed link speeds accepted
// - link speed kept and restored at startup
// - silence past alert time turns laser off
// - alert time 0..110 s, zero disables
// - nine-bit polarity mask, reserved bits zero
// - last command result, zero on success
// - status byte: emission, errors, event, operational
// - result bits unknown, refused, parameter, failed
// - activity judged by per-input polarity bit
module lscp_parser #(
    parameter int unsigned CYC_PER_SEC = 100_000_000 // clock cycles per second
) (
    input wire logic i_mclk, // system clock
    input wire logic i_rst_n, // sync reset, low
    input wire logic i_cmd_valid, // decoded command present
    input wire lscp_pkg::lscp_cmd_e i_cmd_code, // which command
    input wire logic [31:0] i_cmd_arg, // numeric argument
    input wire logic i_random_mode, // random pulsing on
    input wire logic i_link_fail, // internal link failure
    input wire logic i_trigger, // trigger pulse
    input wire logic i_pulse, // optical pulse emitted
    input wire logic [9:0] i_energy, // energy of that pulse
    input wire logic i_emitting, // diode on or standby
    input wire logic i_head_power, // head powered
    input wire logic i_supply_power, // supply powered
    input wire logic [7:0] i_fault_code, // present fault code
    input wire logic i_fault_raise, // fault code raised
    input wire logic [127:0] i_active_codes, // active codes, entry 0 low
    input wire logic [4:0] i_active_num, // count of active codes
    input wire logic [8:0] i_port_pin, // analog port raw levels
    input wire logic i_sys_error, // system error present
    input wire logic i_event, // event summary
    input wire logic i_operational, // operational condition
    input wire logic [2:0] i_stored_baud, // saved speed index
    input wire logic [15:0] i_max_rate, // max repetition rate
    output logic o_cmd_ready, // command may be given
    output logic o_tok_valid, // reply token present
    output var lscp_pkg::lscp_tok_e o_tok_kind, // reply token kind
    output logic [31:0] o_tok_value, // reply number
    output logic o_qsw_fire, // optical pulse fire strobe
    output logic o_laser_off, // watchdog turned laser off
    output logic [2:0] o_baud_sel, // link speed index
    output logic o_baud_store, // save speed index strobe
    output logic [8:0] o_polarity // port polarity mask
);
    import lscp_pkg::*;

    // speed index to bits per second, zero for no speed
    function automatic logic [31:0] lscp_rate(input logic [2:0] k);
        case (k)
            3'h0: lscp_rate = `LSCP_BAUD_0;
            3'h1: lscp_rate = `LSCP_BAUD_1;
            3'h2: lscp_rate = `LSCP_BAUD_2;
            3'h3: lscp_rate = `LSCP_BAUD_3;
            3'h4: lscp_rate = `LSCP_BAUD_4;
            3'h5: lscp_rate = `LSCP_BAUD_5;
            3'h6: lscp_rate = `LSCP_BAUD_6;
            default: lscp_rate = 32'h0;
        endcase
    endfunction : lscp_rate

    // delay engine state
    logic [16:0] acc, next_acc; // head clock phase
    logic head_en; // head clock step enable
    logic dbusy, next_dbusy; // delay running
    logic [12:0] dcnt, next_dcnt; // head steps left
    logic next_fire; // fire next cycle
    logic [11:0] delay, next_delay; // programmed delay count

    // head clock enable and trigger delay
    always_comb begin
        next_acc = acc + `LSCP_ACC_STEP;
        head_en = 1'b0;
        if (next_acc >= `LSCP_ACC_MOD) begin
            next_acc = next_acc - `LSCP_ACC_MOD;
            head_en = 1'b1;
        end
        next_dbusy = dbusy;
        next_dcnt = dcnt;
        next_fire = 1'b0;
        if (!dbusy && i_trigger) begin
            // partial first step not counted, so the wait is never short of the base
            next_dbusy = 1'b1;
            next_dcnt = 13'(`LSCP_BASE_TICKS) + {1'b0, delay};
        end else if (dbusy && head_en) begin
            if (dcnt == 13'h0) begin
                next_fire = 1'b1;
                next_dbusy = 1'b0;
            end else begin
                next_dcnt = dcnt - 13'h1;
            end
        end
    end

    // register delay engine
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            acc <= 17'h0;
            dbusy <= 1'b0;
            dcnt <= 13'h0;
            o_qsw_fire <= 1'b0;
        end else begin
            acc <= next_acc;
            dbusy <= next_dbusy;
            dcnt <= next_dcnt;
            o_qsw_fire <= next_fire;
        end
    end

    // counter state
    logic [26:0] sec_cyc, next_sec_cyc; // second prescaler
    logic sec_tick; // one-second enable
    logic [2:0] hcond; // supply, head, emitter on
    logic [8:0] hsec [3]; // seconds into current tenth hour
    logic [8:0] next_hsec [3];
    logic [31:0] hours [3]; // tenths of hours
    logic [31:0] next_hours [3];
    logic [9:0] ksub, next_ksub; // pulses below a thousand
    logic [31:0] kcnt, next_kcnt; // thousands of pulses
    logic [26:0] wd_cyc, next_wd_cyc; // watchdog cycles
    logic [6:0] wd_sec, next_wd_sec; // watchdog seconds
    logic next_off; // laser off next
    logic cmd_take; // command accepted
    logic [6:0] timeout, next_timeout; // alert time in seconds

    // hour counters, pulse count and watchdog
    always_comb begin
        sec_tick = sec_cyc == 27'(CYC_PER_SEC - 1);
        next_sec_cyc = sec_tick ? 27'h0 : sec_cyc + 27'h1;
        hcond = {i_supply_power, i_head_power, i_emitting};
        for (int k = 0; k < 3; k++) begin
            next_hsec[k] = hsec[k];
            next_hours[k] = hours[k];
            if (hcond[k] && sec_tick) begin
                if (hsec[k] == 9'(`LSCP_HOUR_SEC - 1)) begin
                    next_hsec[k] = 9'h0;
                    next_hours[k] = hours[k] + 32'h1;
                end else begin
                    next_hsec[k] = hsec[k] + 9'h1;
                end
            end
        end
        next_ksub = ksub;
        next_kcnt = kcnt;
        if (i_pulse) begin
            // thousands carry
            if (ksub == `LSCP_KILO) begin
                next_ksub = 10'h0;
                next_kcnt = kcnt + 32'h1;
            end else begin
                next_ksub = ksub + 10'h1;
            end
        end
        next_wd_cyc = wd_cyc;
        next_wd_sec = wd_sec;
        next_off = o_laser_off;
        if (cmd_take) begin
            // any command restarts the countdown
            next_wd_cyc = 27'h0;
            next_wd_sec = 7'h0;
            next_off = 1'b0;
        end else if (timeout != 7'h0 && !o_laser_off) begin
            if (wd_cyc == 27'(CYC_PER_SEC - 1)) begin
                next_wd_cyc = 27'h0;
                next_wd_sec = wd_sec + 7'h1;
            end else begin
                next_wd_cyc = wd_cyc + 27'h1;
            end
            if (wd_sec == timeout) begin
                next_off = 1'b1;
            end
        end
    end

    // register counters
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sec_cyc <= 27'h0;
            hsec <= '{default: 9'h0};
            hours <= '{default: 32'h0};
            ksub <= 10'h0;
            kcnt <= 32'h0;
            wd_cyc <= 27'h0;
            wd_sec <= 7'h0;
            o_laser_off <= 1'b0;
        end else begin
            sec_cyc <= next_sec_cyc;
            hsec <= next_hsec;
            hours <= next_hours;
            ksub <= next_ksub;
            kcnt <= next_kcnt;
            wd_cyc <= next_wd_cyc;
            wd_sec <= next_wd_sec;
            o_laser_off <= next_off;
        end
    end

    // command and reply state
    lscp_state_e st, next_st; // reply sequencer
    lscp_src_e src, next_src; // where list values come from
    logic [5:0] idx, next_idx; // list position
    logic [5:0] len, next_len; // list length
    logic [31:0] one, next_one; // single reply value
    logic [8:0] next_pol; // polarity next
    logic [2:0] next_baud; // speed next
    logic bload, next_bload; // saved speed taken
    logic next_store; // save strobe next
    logic [3:0] lres, next_lres; // last command result
    logic next_tv, next_rdy; // token valid, ready next
    lscp_tok_e next_tk; // token kind next
    logic [31:0] next_tval; // token value next
    logic [7:0] fhist [`LSCP_FH_N]; // fault history
    logic [4:0] fh_n, next_fh_n; // fault history fill
    logic fh_we; // fault history write
    logic [9:0] ehist [`LSCP_EH_N]; // energy history
    logic [5:0] eh_n, next_eh_n; // energy history fill
    logic eh_we; // energy history write
    logic [8:0] act; // per-pin active
    logic [7:0] level, stb; // port mask, status byte
    logic [31:0] elem; // list element at idx
    logic [3:0] res; // result of this command
    logic [2:0] bidx; // speed index searched

    // decode, settings and reply sequencing
    always_comb begin
        act = ~(i_port_pin ^ o_polarity);
        level = {1'b0, act[6], act[5], 1'b0, act[3], act[2], 1'b0, act[8]};
        stb = {i_operational, 1'b0, i_event, 1'b0, i_sys_error, lres != 4'h0,
               1'b0, i_emitting};
        case (src)
            SRC_FH: elem = {24'h0, fhist[idx[3:0]]};
            SRC_EH: elem = {22'h0, ehist[idx]};
            SRC_ACT: elem = {24'h0, i_active_codes[idx[3:0]*8 +: 8]};
            default: elem = one;
        endcase
        cmd_take = i_cmd_valid && o_cmd_ready;
        next_st = st;
        next_src = src;
        next_idx = idx;
        next_len = len;
        next_one = one;
        next_delay = delay;
        next_timeout = timeout;
        next_pol = o_polarity;
        next_baud = o_baud_sel;
        next_bload = 1'b1;
        next_store = 1'b0;
        next_lres = lres;
        next_tv = 1'b0;
        next_tk = o_tok_kind;
        next_tval = o_tok_value;
        res = 4'h0;
        bidx = 3'h7;
        fh_we = i_fault_raise && fh_n < 5'(`LSCP_FH_N);
        next_fh_n = fh_we ? fh_n + 5'h1 : fh_n;
        eh_we = i_pulse && eh_n < 6'(`LSCP_EH_N);
        next_eh_n = eh_we ? eh_n + 6'h1 : eh_n;
        if (!bload) begin
            // restore saved speed once after reset
            next_baud = (lscp_rate(i_stored_baud) != 32'h0) ? i_stored_baud
                                                             : `LSCP_BAUD_DEF;
        end
        for (int k = 0; k < 7; k++) begin
            if (lscp_rate(3'(k)) == i_cmd_arg) bidx = 3'(k);
        end
        case (st)
            ST_IDLE: begin
                if (cmd_take) begin
                    next_st = ST_VAL;
                    next_src = SRC_ONE;
                    next_idx = 6'h0;
                    next_len = 6'h1;
                    next_one = 32'h0;
                    case (i_cmd_code)
                        CMD_DELAY_SET: begin
                            next_st = ST_CR;
                            if (i_random_mode) res[`LSCP_RES_REFUSED] = 1'b1;
                            else if (i_cmd_arg > 32'(`LSCP_DLY_MAX))
                                res[`LSCP_RES_BADPAR] = 1'b1;
                            else next_delay = i_cmd_arg[11:0];
                        end
                        CMD_DELAY_Q: next_one = {20'h0, delay};
                        CMD_MAX_RATE_Q: next_one = {16'h0, i_max_rate};
                        CMD_EMIT_HRS_Q: next_one = hours[0];
                        CMD_HEAD_HRS_Q: next_one = hours[1];
                        CMD_SUPPLY_HRS_Q: next_one = hours[2];
                        CMD_FAULT_Q: next_one = {24'h0, i_fault_code};
                        CMD_FAULT_HIST_Q: begin
                            next_src = SRC_FH;
                            next_len = {1'b0, fh_n};
                        end
                        CMD_FAULT_LIST_Q: begin
                            next_src = SRC_ACT;
                            next_len = (i_active_num > 5'd16) ? 6'd16 : {1'b0, i_active_num};
                        end
                        CMD_ENERGY_HIST_Q: begin
                            next_src = SRC_EH;
                            next_len = eh_n;
                        end
                        CMD_PULSE_Q: next_one = kcnt;
                        CMD_PORT_Q: next_one = {24'h0, level};
                        CMD_LRES_Q: next_one = {28'h0, lres};
                        CMD_STB_Q: next_one = {24'h0, stb};
                        CMD_SPEED_SET: begin
                            next_st = ST_CR;
                            if (bidx == 3'h7) res[`LSCP_RES_BADPAR] = 1'b1;
                            else begin
                                next_baud = bidx;
                                next_store = 1'b1;
                            end
                        end
                        CMD_SPEED_Q: next_one = lscp_rate(o_baud_sel);
                        CMD_TMO_SET: begin
                            next_st = ST_CR;
                            if (i_cmd_arg > 32'(`LSCP_WD_MAX)) res[`LSCP_RES_BADPAR] = 1'b1;
                            else next_timeout = i_cmd_arg[6:0];
                        end
                        CMD_TMO_Q: next_one = {25'h0, timeout};
                        CMD_POL_SET: begin
                            next_st = ST_CR;
                            if (i_cmd_arg > `LSCP_POL_MAX) res[`LSCP_RES_BADPAR] = 1'b1;
                            else next_pol = i_cmd_arg[8:0] & ~`LSCP_POL_RSV;
                        end
                        CMD_POL_Q: next_one = {23'h0, o_polarity};
                        default: begin
                            next_st = ST_CR;
                            res[`LSCP_RES_UNKNOWN] = 1'b1;
                        end
                    endcase
                    if (i_link_fail) res[`LSCP_RES_FAILED] = 1'b1;
                    next_lres = res;
                    if (next_len == 6'h0) begin
                        next_src = SRC_ONE; // empty list answers zero
                        next_len = 6'h1;
                    end
                    if (res != 4'h0) begin
                        // refused command answers an error mark
                        next_st = ST_CR;
                        next_tv = 1'b1;
                        next_tk = TOK_ERR;
                    end
                end
            end
            ST_VAL: begin
                next_tv = 1'b1;
                next_tk = TOK_VAL;
                next_tval = elem;
                next_st = (idx + 6'h1 == len) ? ST_CR : ST_BLANK;
            end
            ST_BLANK: begin
                next_tv = 1'b1;
                next_tk = TOK_BLANK;
                next_idx = idx + 6'h1;
                next_st = ST_VAL;
            end
            ST_CR: begin
                next_tv = 1'b1;
                next_tk = TOK_CR;
                next_st = ST_LF;
                if (src == SRC_EH) next_eh_n = 6'h0; // readout empties buffer
            end
            ST_LF: begin
                next_tv = 1'b1;
                next_tk = TOK_LF;
                next_st = ST_IDLE;
            end
            default: next_st = ST_IDLE;
        endcase
        next_rdy = next_st == ST_IDLE;
    end

    // register command state
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st <= ST_IDLE;
            src <= SRC_ONE;
            idx <= 6'h0;
            len <= 6'h0;
            one <= 32'h0;
            delay <= 12'h0;
            timeout <= 7'h0;
            o_polarity <= 9'h0;
            o_baud_sel <= `LSCP_BAUD_DEF;
            bload <= 1'b0;
            o_baud_store <= 1'b0;
            lres <= 4'h0;
            o_tok_valid <= 1'b0;
            o_tok_kind <= TOK_VAL;
            o_tok_value <= 32'h0;
            o_cmd_ready <= 1'b0;
            fh_n <= 5'h0;
            eh_n <= 6'h0;
        end else begin
            st <= next_st;
            src <= next_src;
            idx <= next_idx;
            len <= next_len;
            one <= next_one;
            delay <= next_delay;
            timeout <= next_timeout;
            o_polarity <= next_pol;
            o_baud_sel <= next_baud;
            bload <= next_bload;
            o_baud_store <= next_store;
            lres <= next_lres;
            o_tok_valid <= next_tv;
            o_tok_kind <= next_tk;
            o_tok_value <= next_tval;
            o_cmd_ready <= next_rdy;
            fh_n <= next_fh_n;
            eh_n <= next_eh_n;
        end
    end

    // history memories, no reset needed
    always_ff @(posedge i_mclk) begin
        if (fh_we) fhist[fh_n[3:0]] <= i_fault_code;
        if (eh_we) ehist[eh_n] <= i_energy;
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    delay_keep_a: assert property (
        cmd_take && i_cmd_code == CMD_DELAY_SET && i_random_mode |=> $stable(delay))
        else $error("delay changed in random mode");
    delay_range_a: assert property (delay <= `LSCP_DLY_MAX)
        else $error("delay count out of range");
    fire_late_a: assert property ($rose(dbusy) |=> !o_qsw_fire [*8])
        else $error("fire came before base delay");
    wd_range_a: assert property (timeout <= `LSCP_WD_MAX)
        else $error("alert time out of range");
    wd_quiet_a: assert property (timeout == 7'h0 && !o_laser_off |=> !o_laser_off)
        else $error("laser off with watchdog disabled");
    reply_end_a: assert property (
        o_tok_valid && o_tok_kind == TOK_CR |=> o_tok_valid && o_tok_kind == TOK_LF)
        else $error("carriage return not followed by line feed");
    pol_rsv_a: assert property ((o_polarity & `LSCP_POL_RSV) == 9'h0)
        else $error("reserved polarity bit set");
    port_level_a: assert property (
        cmd_take && i_cmd_code == CMD_PORT_Q && !i_link_fail
        |-> ##2 o_tok_kind == TOK_VAL && o_tok_value == {24'h0, $past(level, 2)})
        else $error("port level reply wrong");
    fault_cap_a: assert property (fh_n <= 5'd16)
        else $error("fault history overfilled");
    lres_ok_a: assert property (
        cmd_take && i_cmd_code == CMD_LRES_Q && !i_link_fail |=> lres == 4'h0)
        else $error("query did not leave success result");
endmodule : lscp_parser
`default_nettype wire

// [core/lscp_consts.svh]
// timing counts, limits and field positions for the laser command parser
`ifndef LSCP_CONSTS_SVH
`define LSCP_CONSTS_SVH
`define LSCP_CLK_KHZ 100000
`define LSCP_HEAD_KHZ 20340
`define LSCP_ACC_STEP 17'd20340
`define LSCP_ACC_MOD 17'd100000
`define LSCP_BASE_NS 3000
`define LSCP_BASE_TICKS (`LSCP_BASE_NS * `LSCP_HEAD_KHZ / 1000000)
`define LSCP_DLY_MAX 12'd3500
`define LSCP_HOUR_MIN 6
`define LSCP_HOUR_SEC (`LSCP_HOUR_MIN * 60)
`define LSCP_WD_MAX 7'd110
`define LSCP_FH_N 16
`define LSCP_EH_N 50
`define LSCP_KILO 10'd999
`define LSCP_POL_MAX 32'd511
`define LSCP_POL_RSV 9'h090
`define LSCP_RES_UNKNOWN 0
`define LSCP_RES_REFUSED 1
`define LSCP_RES_BADPAR 2
`define LSCP_RES_FAILED 3
`define LSCP_BAUD_DEF 3'd1
`define LSCP_BAUD_0 32'd4800
`define LSCP_BAUD_1 32'd9600
`define LSCP_BAUD_2 32'd14400
`define LSCP_BAUD_3 32'd19200
`define LSCP_BAUD_4 32'd28800
`define LSCP_BAUD_5 32'd38400
`define LSCP_BAUD_6 32'd57600
`endif

// [core/lscp_pkg.sv]
// types shared by the laser command parser
package lscp_pkg;
    typedef enum logic [4:0] {
        CMD_DELAY_SET, CMD_DELAY_Q, CMD_MAX_RATE_Q, CMD_EMIT_HRS_Q,
        CMD_HEAD_HRS_Q, CMD_SUPPLY_HRS_Q, CMD_FAULT_Q, CMD_FAULT_HIST_Q,
        CMD_FAULT_LIST_Q, CMD_ENERGY_HIST_Q, CMD_PULSE_Q, CMD_PORT_Q,
        CMD_LRES_Q, CMD_STB_Q, CMD_SPEED_SET, CMD_SPEED_Q, CMD_TMO_SET,
        CMD_TMO_Q, CMD_POL_SET, CMD_POL_Q, CMD_OTHER
    } lscp_cmd_e;
    typedef enum logic [2:0] {TOK_VAL, TOK_BLANK, TOK_CR, TOK_LF, TOK_ERR} lscp_tok_e;
    typedef enum logic [1:0] {SRC_ONE, SRC_FH, SRC_EH, SRC_ACT} lscp_src_e;
    typedef enum logic [2:0] {ST_IDLE, ST_VAL, ST_BLANK, ST_CR, ST_LF} lscp_state_e;
endpackage : lscp_pkg

// [verification/lscp_host.sv]
// host model that offers decoded commands to the parser
`timescale 1ns/1ps
`default_nettype none
module lscp_host (
    input wire logic i_mclk, // system clock
    input wire logic i_ready, // parser can take a command
    output var logic o_valid, // command offered
    output var lscp_pkg::lscp_cmd_e o_code, // command code
    output var logic [31:0] o_arg // command argument
);
    import lscp_pkg::*;
    logic rdy_q = 1'h0; // ready as it stood before the last edge
    initial o_valid = 1'h0;
    initial o_code = CMD_OTHER;
    initial o_arg = 32'h0;
    // mid-cycle copy of ready avoids racing the edge that updates it
    always @(negedge i_mclk) rdy_q = i_ready;
    // offer one command, hold it to the taking edge, then scramble the argument
    task automatic send(input lscp_cmd_e c, input logic [31:0] a);
        @(posedge i_mclk);
        o_valid <= 1'h1;
        o_code <= c;
        o_arg <= a;
        do @(posedge i_mclk); while (rdy_q !== 1'h1);
        o_valid <= 1'h0;
        o_arg <= ~a;
    endtask : send
endmodule : lscp_host
`default_nettype wire

// [verification/laser_status_command_parser_bench.sv]
// self-checking bench for the laser command parser
`timescale 1ns/1ps
`default_nettype none
module laser_status_command_parser_bench;
    import lscp_pkg::*;
    logic i_mclk = 1'h0, i_rst_n = 1'h0, i_random_mode = 1'h0, i_link_fail = 1'h0;
    logic i_trigger = 1'h0, i_pulse = 1'h0, i_emitting = 1'h0, i_head_power = 1'h0;
    logic i_supply_power = 1'h0, i_fault_raise = 1'h0, i_sys_error = 1'h0, i_event = 1'h1;
    logic i_operational = 1'h0, i_cmd_valid, o_cmd_ready, o_tok_valid, o_qsw_fire;
    logic o_laser_off, o_baud_store;
    lscp_cmd_e i_cmd_code;
    lscp_tok_e o_tok_kind, fk;
    logic [31:0] i_cmd_arg, o_tok_value, fv;
    logic [127:0] i_active_codes = 128'h17;
    logic [9:0] i_energy = 10'h1c7;
    logic [7:0] i_fault_code = 8'h0c;
    logic [4:0] i_active_num = 5'h0;
    logic [8:0] i_port_pin = 9'h0, o_polarity;
    logic [2:0] i_stored_baud = 3'h3, o_baud_sel;
    logic [15:0] i_max_rate = 16'h1388;
    int mismatches = 0, check_count = 0, n, stores = 0;
    // one second is twenty cycles, so an hour tenth is 7200 cycles
    lscp_parser #(.CYC_PER_SEC(20)) i_lscp_parser (.i_mclk, .i_rst_n, .i_cmd_valid,
        .i_cmd_code, .i_cmd_arg, .i_random_mode, .i_link_fail, .i_trigger, .i_pulse,
        .i_energy, .i_emitting, .i_head_power, .i_supply_power, .i_fault_code,
        .i_fault_raise, .i_active_codes, .i_active_num, .i_port_pin, .i_sys_error,
        .i_event, .i_operational, .i_stored_baud, .i_max_rate, .o_cmd_ready, .o_tok_valid,
        .o_tok_kind, .o_tok_value, .o_qsw_fire, .o_laser_off, .o_baud_sel, .o_baud_store,
        .o_polarity);
    lscp_host i_lscp_host (.i_mclk(i_mclk), .i_ready(o_cmd_ready), .o_valid(i_cmd_valid),
        .o_code(i_cmd_code), .o_arg(i_cmd_arg));
    // 100 MHz clock
    initial forever #5 i_mclk = ~i_mclk;
    // count speed save strobes away from the edge that launches them
    always @(negedge i_mclk) if (o_baud_store === 1'h1) stores++;
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // send a command, keep its first reply token, wait for the closing line feed
    task automatic cmd(input lscp_cmd_e c, input logic [31:0] a, input lscp_tok_e k,
                       input logic [31:0] v);
        bit got;
        got = 1'b0;
        fk = TOK_CR;
        i_lscp_host.send(c, a);
        for (int i = 0; i < 12; i++) begin
            // first look is just after the taking edge, where an error mark stands
            #1;
            if (o_tok_valid === 1'h1 && !got) begin
                got = 1'b1;
                fk = o_tok_kind;
                fv = o_tok_value;
            end
            if (o_tok_valid === 1'h1 && o_tok_kind === TOK_LF) break;
            @(posedge i_mclk);
        end
        check({29'h0, fk}, {29'h0, k});
        if (k == TOK_VAL) check(fv, v);
    endtask : cmd
    // count edges until a flag rises, bounded
    task automatic wait_hi(ref logic f);
        for (n = 1; n < 400; n++) begin
            @(posedge i_mclk);
            #1;
            if (f === 1'h1) break;
        end
    endtask : wait_hi
    // print the verdict and stop
    task automatic results;
        if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // hang guard, about two and a half times the eight thousand cycles the sequence needs
    initial begin
        #200000;
        mismatches++;
        results();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        repeat (2) @(posedge i_mclk);
        #1;
        check(o_baud_sel, 3'h3);
        check(o_polarity, 9'h0);
        cmd(CMD_FAULT_LIST_Q, 32'h0, TOK_VAL, 32'h0);
        cmd(CMD_ENERGY_HIST_Q, 32'h0, TOK_VAL, 32'h0);
        cmd(CMD_FAULT_Q, 32'h0, TOK_VAL, 32'hc);
        @(posedge i_mclk);
        i_pulse <= 1'h1;
        i_fault_raise <= 1'h1;
        i_active_num <= 5'h1;
        @(posedge i_mclk);
        i_pulse <= 1'h0;
        i_fault_raise <= 1'h0;
        cmd(CMD_FAULT_HIST_Q, 32'h0, TOK_VAL, 32'hc);
        cmd(CMD_FAULT_LIST_Q, 32'h0, TOK_VAL, 32'h17);
        cmd(CMD_ENERGY_HIST_Q, 32'h0, TOK_VAL, 32'h1c7);
        cmd(CMD_ENERGY_HIST_Q, 32'h0, TOK_VAL, 32'h0);
        cmd(CMD_PULSE_Q, 32'h0, TOK_VAL, 32'h0);
        cmd(CMD_DELAY_SET, 32'hdad, TOK_ERR, 32'h0);
        cmd(CMD_DELAY_SET, 32'hdac, TOK_CR, 32'h0);
        i_random_mode <= 1'h1;
        cmd(CMD_DELAY_SET, 32'h5, TOK_ERR, 32'h0);
        cmd(CMD_DELAY_Q, 32'h0, TOK_VAL, 32'hdac);
        i_random_mode <= 1'h0;
        cmd(CMD_DELAY_SET, 32'h0, TOK_CR, 32'h0);
        @(posedge i_mclk);
        i_trigger <= 1'h1;
        @(posedge i_mclk);
        i_trigger <= 1'h0;
        wait_hi(o_qsw_fire);
        check(n >= 298 && n <= 302, 32'h1);
        cmd(CMD_OTHER, 32'h0, TOK_ERR, 32'h0);
        cmd(CMD_STB_Q, 32'h0, TOK_VAL, 32'h24);
        cmd(CMD_LRES_Q, 32'h0, TOK_VAL, 32'h0);
        cmd(CMD_TMO_SET, 32'h6f, TOK_ERR, 32'h0);
        cmd(CMD_LRES_Q, 32'h0, TOK_VAL, 32'h4);
        i_link_fail <= 1'h1;
        cmd(CMD_TMO_Q, 32'h0, TOK_ERR, 32'h0);
        i_link_fail <= 1'h0;
        cmd(CMD_LRES_Q, 32'h0, TOK_VAL, 32'h8);
        cmd(CMD_TMO_SET, 32'h3, TOK_CR, 32'h0);
        wait_hi(o_laser_off);
        check(n >= 35 && n <= 70, 32'h1);
        cmd(CMD_TMO_SET, 32'h0, TOK_CR, 32'h0);
        repeat (100) @(posedge i_mclk);
        check(o_laser_off, 1'h0);
        cmd(CMD_SPEED_SET, 32'h3840, TOK_CR, 32'h0);
        check(o_baud_sel, 3'h2);
        cmd(CMD_SPEED_SET, 32'h3a98, TOK_ERR, 32'h0);
        cmd(CMD_SPEED_Q, 32'h0, TOK_VAL, 32'h3840);
        check(stores, 32'h1);
        cmd(CMD_POL_SET, 32'h1ff, TOK_CR, 32'h0);
        check(o_polarity, 9'h16f);
        cmd(CMD_POL_SET, 32'h200, TOK_ERR, 32'h0);
        i_port_pin <= 9'h104;
        cmd(CMD_PORT_Q, 32'h0, TOK_VAL, 32'h5);
        i_emitting <= 1'h1;
        i_head_power <= 1'h1;
        i_supply_power <= 1'h1;
        i_pulse <= 1'h1;
        repeat (999) @(posedge i_mclk);
        i_pulse <= 1'h0;
        repeat (6401) @(posedge i_mclk);
        i_emitting <= 1'h0;
        i_head_power <= 1'h0;
        i_supply_power <= 1'h0;
        cmd(CMD_EMIT_HRS_Q, 32'h0, TOK_VAL, 32'h1);
        cmd(CMD_HEAD_HRS_Q, 32'h0, TOK_VAL, 32'h1);
        cmd(CMD_SUPPLY_HRS_Q, 32'h0, TOK_VAL, 32'h1);
        cmd(CMD_MAX_RATE_Q, 32'h0, TOK_VAL, 32'h1388);
        cmd(CMD_PULSE_Q, 32'h0, TOK_VAL, 32'h1);
        results();
    end
endmodule : laser_status_command_parser_bench
`default_nettype wire
